// ---- tec_top.sv ----
// Timer/event counters, 8-bit and 16-bit, with frequency divider output
// Function
// - Mode 10 selects interval timer
// - Mode 11 selects pulse width measurement
// - Narrow counter clocked by prescaled system clock
// - Wide counter clocked by sub or fsys/4
// - Event mode counts pin edges, no prescale
// - Counter runs only while run bit set
// - Overflow raises request, reloads, keeps counting
// - Interrupt passes only when enabled
// - Edge select picks rising or falling
// - Event counting continues powered down, wakes
// - Pulse mode run bit only arms
// - Edge select picks pulse polarity
// - Pulse end clears run bit, ignores pin
// - Timer and event modes never self-clear
// - Counter holds residue after pulse end
// - Pulse mode uses edges; overflow still reloads
// - Divider toggles on selected counter overflow
// - Option routes divider to shared pin
// - Divider needs output direction and data one
// - Stopped preload write loads counter immediately
// - Overflow past all ones; zero preload full
// - Wide low byte buffered, high read latches
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "tec_map.svh"

module tec_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire tec_pkg::tec_ctrl_t ctrl,
    input  wire logic             pre_wr,
    input  wire logic [WIDTH-1:0] pre_data,
    input  wire logic             tick,
    input  wire logic             pin_s,
    output logic      [WIDTH-1:0] cnt_o,
    output logic                  ovf_o,
    output logic                  clr_o
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] pre_r;
    logic             pin_prev_r;
    logic             meas_r;
    logic             ovf_r;
    logic             clr_r;
    logic             rise;
    logic             fall;
    logic             run;
    logic             start_e;
    logic             ret_e;
    logic             inc;
    logic [1:0]       mode;

    if (WIDTH < 2 || WIDTH > 16) begin : g_chk
        $error("tec_unit: WIDTH must be 2..16");
    end

    // Edge detection on the synchronised pin
    assign rise    = pin_s & ~pin_prev_r;
    assign fall    = ~pin_s & pin_prev_r;
    assign mode    = ctrl.operating_mode_pair;
    assign run     = ctrl.run_enable_bit;
    // Low select: pulse starts falling, ends rising
    assign start_e = ctrl.active_edge_select ? rise : fall;
    assign ret_e   = ctrl.active_edge_select ? fall : rise;

    // Count qualifier per mode; mode 00 never counts
    always_comb begin
        inc = 1'b0;
        case (mode)
            `TEC_MODE_TIMER: inc = run & tick;
            `TEC_MODE_EVENT: inc = run &
                                   (ctrl.active_edge_select ?
                                    fall : rise);
            `TEC_MODE_PULSE: inc = run & meas_r & tick;
            default:         inc = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_s;
        end
    end

    // Pulse measurement: armed by run, opened and closed by edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_r <= 1'b0;
            clr_r  <= 1'b0;
        end else begin
            clr_r <= 1'b0;
            if (mode != `TEC_MODE_PULSE || !run) begin
                meas_r <= 1'b0;
            end else if (!meas_r && start_e) begin
                meas_r <= 1'b1;
            end else if (meas_r && ret_e) begin
                meas_r <= 1'b0;
                clr_r  <= 1'b1;
            end
        end
    end

    // Preload register; unknown at power-on in silicon, zero here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
        end else if (pre_wr) begin
            pre_r <= pre_data;
        end
    end

    // Counter: reload on overflow, residue held when stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= 1'b0;
            if (pre_wr && !run) begin
                cnt_r <= pre_data;
            end else if (inc) begin
                if (cnt_r == '1) begin
                    cnt_r <= pre_r;
                    ovf_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + WIDTH'(1);
                end
            end
        end
    end

    assign cnt_o = cnt_r;
    assign ovf_o = ovf_r;
    assign clr_o = clr_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ovf_reload: assert property (
        inc && cnt_r == '1 && !pre_wr |=> ovf_r && cnt_r == $past(pre_r))
        else $error("overflow did not reload preload");
    a_event_step: assert property (
        mode == `TEC_MODE_EVENT && run && !ctrl.active_edge_select &&
        rise && cnt_r != '1 && !pre_wr |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("event edge not counted");
    a_stop_hold: assert property (
        !run && !pre_wr |=> $stable(cnt_r))
        else $error("counter moved while stopped");
    a_arm_only: assert property (
        mode == `TEC_MODE_PULSE && run && !meas_r && !pre_wr
        |=> $stable(cnt_r))
        else $error("pulse counter ran before edge");
    a_pulse_end: assert property (
        mode == `TEC_MODE_PULSE && run && meas_r && ret_e
        |=> clr_r && !meas_r)
        else $error("pulse end not flagged");
    c_overflow: cover property (ovf_r);
    c_pulse_done: cover property (clr_r);
endmodule

module tec_top #(
    parameter int W0 = 8,
    parameter int W1 = 16
) (
    input  wire logic       REF_CLK,
    input  wire logic       RESET_N,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       TMR0_PIN,
    input  wire logic       TMR1_PIN,
    input  wire logic       SUB_CLK,
    input  wire logic       PWR_DOWN,
    input  wire logic       PA3_IN,
    output logic            PA3_OUT,
    output logic            PA3_OE_N,
    output logic            IRQ0,
    output logic            IRQ1,
    output logic            WAKE
);
    tec_pkg::tec_ctrl_t ctrl0_r;
    tec_pkg::tec_ctrl_t ctrl1_r;
    tec_pkg::tec_port_t port_r;
    logic [1:0]    cfg_r;
    logic [1:0]    inten_r;
    logic [7:0]    lo_wbuf_r;
    logic [7:0]    lo_rbuf_r;
    logic [7:0]    rdata_nxt;
    logic [6:0]    pre_div_r;
    logic [1:0]    sys4_r;
    logic [1:0]    t0_sync_r;
    logic [1:0]    t1_sync_r;
    logic [2:0]    sub_sync_r;
    logic [1:0]    pa_sync_r;
    logic          pfd_q_r;
    logic          tick0;
    logic          tick1;
    logic [W0-1:0] cnt0;
    logic [W1-1:0] cnt1;
    logic          ovf0;
    logic          ovf1;
    logic          clr0;
    logic          clr1;
    logic          pfd_ovf;
    logic          pa3_out_nxt;

    if (W0 != 8 || W1 != 16) begin : g_chk
        $error("tec_top: byte register map needs W0=8, W1=16");
    end

    // Prescaler tap mask: rate 0 passes every clock, 7 divides by 128
    function automatic logic [6:0] rate_mask(input logic [2:0] r);
        rate_mask = 7'(8'h7F >> (3'h7 - r));
    endfunction

    // Two-flop synchronisers; third stage only feeds edge detect
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            t0_sync_r  <= 2'h0;
            t1_sync_r  <= 2'h0;
            sub_sync_r <= 3'h0;
            pa_sync_r  <= 2'h0;
        end else begin
            t0_sync_r  <= {t0_sync_r[0], TMR0_PIN};
            t1_sync_r  <= {t1_sync_r[0], TMR1_PIN};
            sub_sync_r <= {sub_sync_r[1:0], SUB_CLK};
            pa_sync_r  <= {pa_sync_r[0], PA3_IN};
        end
    end

    // Free-running prescaler and fsys/4 divider
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pre_div_r <= 7'h00;
            sys4_r    <= 2'h0;
        end else begin
            pre_div_r <= pre_div_r + 7'h01;
            sys4_r    <= sys4_r + 2'h1;
        end
    end

    // Tick sources for both counters
    assign tick0 = (pre_div_r & rate_mask(ctrl0_r.prescale_rate_field))
                   == rate_mask(ctrl0_r.prescale_rate_field);
    assign tick1 = ctrl1_r.clock_source_select
                   ? (sub_sync_r[1] & ~sub_sync_r[2])
                   : (sys4_r == `TEC_SYS4_LAST);

    tec_unit #(.WIDTH(W0)) u_cnt0 (
        .clk      (REF_CLK),
        .rst_n    (RESET_N),
        .ctrl     (ctrl0_r),
        .pre_wr   (WR && ADDR == `TEC_OFF_CNT0),
        .pre_data (WDATA),
        .tick     (tick0),
        .pin_s    (t0_sync_r[1]),
        .cnt_o    (cnt0),
        .ovf_o    (ovf0),
        .clr_o    (clr0)
    );

    tec_unit #(.WIDTH(W1)) u_cnt1 (
        .clk      (REF_CLK),
        .rst_n    (RESET_N),
        .ctrl     (ctrl1_r),
        .pre_wr   (WR && ADDR == `TEC_OFF_CNT1H),
        .pre_data ({WDATA, lo_wbuf_r}),
        .tick     (tick1),
        .pin_s    (t1_sync_r[1]),
        .cnt_o    (cnt1),
        .ovf_o    (ovf1),
        .clr_o    (clr1)
    );

    // Control registers; software write wins over the hardware stop
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl0_r <= tec_pkg::tec_ctrl_t'(`TEC_CTRL_RST);
            ctrl1_r <= tec_pkg::tec_ctrl_t'(`TEC_CTRL_RST);
        end else begin
            if (WR && ADDR == `TEC_OFF_CTRL0) begin
                ctrl0_r <= tec_pkg::tec_ctrl_t'(WDATA);
            end else if (clr0) begin
                ctrl0_r.run_enable_bit <= 1'b0;
            end
            if (WR && ADDR == `TEC_OFF_CTRL1) begin
                ctrl1_r <= tec_pkg::tec_ctrl_t'(WDATA);
            end else if (clr1) begin
                ctrl1_r.run_enable_bit <= 1'b0;
            end
        end
    end

    // Interrupt enables, port bits and option bits
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            inten_r <= `TEC_INTEN_RST;
            port_r  <= tec_pkg::tec_port_t'(`TEC_PORT_RST);
            cfg_r   <= `TEC_CFG_RST;
        end else if (WR) begin
            if (ADDR == `TEC_OFF_INTEN) begin
                inten_r <= WDATA[1:0];
            end else if (ADDR == `TEC_OFF_PORT) begin
                port_r <= tec_pkg::tec_port_t'(WDATA[1:0]);
            end else if (ADDR == `TEC_OFF_CFG) begin
                cfg_r <= WDATA[1:0];
            end
        end
    end

    // Wide counter byte buffers: write low first, read high first
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lo_wbuf_r <= 8'h00;
            lo_rbuf_r <= 8'h00;
        end else begin
            if (WR && ADDR == `TEC_OFF_CNT1L) begin
                lo_wbuf_r <= WDATA;
            end
            if (RD && ADDR == `TEC_OFF_CNT1H) begin
                lo_rbuf_r <= cnt1[7:0];
            end
        end
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        if (ADDR == `TEC_OFF_CTRL0) begin
            rdata_nxt = ctrl0_r;
        end else if (ADDR == `TEC_OFF_CNT0) begin
            rdata_nxt = cnt0;
        end else if (ADDR == `TEC_OFF_CTRL1) begin
            rdata_nxt = ctrl1_r;
        end else if (ADDR == `TEC_OFF_CNT1L) begin
            rdata_nxt = lo_rbuf_r;
        end else if (ADDR == `TEC_OFF_CNT1H) begin
            rdata_nxt = cnt1[15:8];
        end else if (ADDR == `TEC_OFF_INTEN) begin
            rdata_nxt = {6'h00, inten_r};
        end else if (ADDR == `TEC_OFF_PORT) begin
            rdata_nxt = {5'h00, pa_sync_r[1], port_r};
        end else if (ADDR == `TEC_OFF_CFG) begin
            rdata_nxt = {6'h00, cfg_r};
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? rdata_nxt : 8'h00;
        end
    end

    // Divider flop toggles on the option-selected overflow
    assign pfd_ovf = cfg_r[`TEC_CFG_PFD_SRC] ? ovf1 : ovf0;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pfd_q_r <= 1'b0;
        end else if (pfd_ovf) begin
            pfd_q_r <= ~pfd_q_r;
        end
    end

    // Pin value: data bit gates the divider, so data 0 drives low
    always_comb begin
        if (cfg_r[`TEC_CFG_PFD_EN]) begin
            pa3_out_nxt = port_r.divider_pin_data_bit & pfd_q_r;
        end else begin
            pa3_out_nxt = port_r.divider_pin_data_bit;
        end
    end

    // Pin drive; direction bit high makes it an input
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PA3_OUT  <= 1'b0;
            PA3_OE_N <= 1'b1;
        end else begin
            PA3_OUT  <= pa3_out_nxt;
            PA3_OE_N <= port_r.port_a_direction_reg;
        end
    end

    // Requests gated by enables; wake ignores enables
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ0 <= 1'b0;
            IRQ1 <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            IRQ0 <= ovf0 & inten_r[`TEC_INT_EN0];
            IRQ1 <= ovf1 & inten_r[`TEC_INT_EN1];
            WAKE <= (ovf0 | ovf1) & PWR_DOWN;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    a_irq_gate: assert property (
        ovf0 |=> IRQ0 == $past(inten_r[`TEC_INT_EN0]))
        else $error("interrupt gating wrong");
    a_pfd_toggle: assert property (
        pfd_ovf |=> pfd_q_r != $past(pfd_q_r))
        else $error("divider did not toggle");
    a_pin_low: assert property (
        !port_r.divider_pin_data_bit |=> !PA3_OUT)
        else $error("pin not low with data zero");
    a_run_clear: assert property (
        clr0 && !(WR && ADDR == `TEC_OFF_CTRL0)
        |=> !ctrl0_r.run_enable_bit)
        else $error("run bit not cleared at pulse end");
    a_lo_latch: assert property (
        RD && ADDR == `TEC_OFF_CNT1H |=> lo_rbuf_r == $past(cnt1[7:0]))
        else $error("low byte not latched");
    a_wake_down: assert property (
        ovf1 && PWR_DOWN |=> WAKE)
        else $error("no wake on overflow");
    c_pfd_run: cover property (pfd_ovf ##1 PA3_OUT);
    c_irq1: cover property (IRQ1);
    c_wake: cover property (WAKE);
endmodule

// ---- tec_map.svh ----
// Register offsets, codes and reset values of the timer/event counter
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// Register offsets on the plain register port
`define TEC_OFF_CTRL0   4'h0
`define TEC_OFF_CNT0    4'h1
`define TEC_OFF_CTRL1   4'h2
`define TEC_OFF_CNT1L   4'h3
`define TEC_OFF_CNT1H   4'h4
`define TEC_OFF_INTEN   4'h5
`define TEC_OFF_PORT    4'h6
`define TEC_OFF_CFG     4'h7

// Operating mode pair codes
`define TEC_MODE_OFF    2'h0
`define TEC_MODE_EVENT  2'h1
`define TEC_MODE_TIMER  2'h2
`define TEC_MODE_PULSE  2'h3

// Bit positions in the port, option and interrupt enable registers
`define TEC_PORT_DIR    0
`define TEC_PORT_DATA   1
`define TEC_CFG_PFD_EN  0
`define TEC_CFG_PFD_SRC 1
`define TEC_INT_EN0     0
`define TEC_INT_EN1     1

// Reset values
`define TEC_CTRL_RST    8'h00
`define TEC_PORT_RST    2'h1
`define TEC_CFG_RST     2'h0
`define TEC_INTEN_RST   2'h0

// Divider for the fsys/4 source of the wide counter
`define TEC_SYS4_LAST   2'h3

`endif

// ---- tec_pkg.sv ----
// Types shared by the timer/event counter block
package tec_pkg;

    // Timer control register layout
    typedef struct packed {
        logic [1:0] operating_mode_pair;
        logic       clock_source_select;
        logic       run_enable_bit;
        logic       active_edge_select;
        logic [2:0] prescale_rate_field;
    } tec_ctrl_t;

    // Shared pin port bits
    typedef struct packed {
        logic divider_pin_data_bit;
        logic port_a_direction_reg;
    } tec_port_t;

endpackage

// ---- tec_pin_src.sv ----
// Model of the pulse and event source on the two timer pins
`timescale 1ns/10ps

module tec_pin_src (
    input  wire logic clk,
    output logic      pin0,
    output logic      pin1
);
    // A driven source never floats, so the last level simply stays
    initial begin
        pin0 = 1'b0;
        pin1 = 1'b0;
    end

    // Drive a level on the first pin and hold it for n clocks
    task automatic level(input logic v, input int n);
        @(posedge clk);
        pin0 <= v;
        repeat (n) @(posedge clk);
    endtask

    // Drive a level on the second pin and hold it for n clocks
    task automatic level1(input logic v, input int n);
        @(posedge clk);
        pin1 <= v;
        repeat (n) @(posedge clk);
    endtask

    // Full pulses from the idle level: away, then back again
    task automatic pulses(input int k, input int n);
        repeat (k) begin
            level(~pin0, n);
            level(~pin0, n);
        end
    endtask
endmodule

// ---- tec_top_tb_top.sv ----
// Self-checking bench for the timer/event counter block
`timescale 1ns/10ps
`include "tec_map.svh"

module tec_top_tb_top;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } tec_row_t;

    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       sub_clk  = 1'b0;
    logic       pwr_down = 1'b0;
    logic       pa3_in   = 1'b0;
    logic       pa3_q    = 1'b0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic       pin0;
    logic       pin1;
    logic       pa3_out;
    logic       pa3_oe_n;
    logic       irq0;
    logic       irq1;
    logic       wake;
    int         err_total = 0;
    int         n_tests   = 0;
    int         n_irq0    = 0;
    int         n_irq1    = 0;
    int         n_wake    = 0;
    int         n_tog     = 0;
    logic [2:0] rates [3] = '{3'h0, 3'h3, 3'h7};
    logic [7:0] rst_q [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h01, 8'h00};
    // Plain register rows; unmapped offsets must read back zero
    tec_row_t   rows [6] = '{
        '{`TEC_OFF_CTRL0, 8'h05, 8'h05},
        '{`TEC_OFF_CNT0,  8'h5A, 8'h5A},
        '{`TEC_OFF_CTRL1, 8'h25, 8'h25},
        '{`TEC_OFF_INTEN, 8'hFF, 8'h03},
        '{`TEC_OFF_CFG,   8'hFE, 8'h02},
        '{4'h9,           8'hFF, 8'h00}};

    always #20 clk = ~clk;

    tec_top i_tec_top (.REF_CLK(clk), .RESET_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TMR0_PIN(pin0),
        .TMR1_PIN(pin1), .SUB_CLK(sub_clk), .PWR_DOWN(pwr_down),
        .PA3_IN(pa3_in), .PA3_OUT(pa3_out), .PA3_OE_N(pa3_oe_n),
        .IRQ0(irq0), .IRQ1(irq1), .WAKE(wake));

    tec_pin_src i_tec_pin_src (.clk(clk), .pin0(pin0), .pin1(pin1));

    // Pulse and toggle counts, sampled before the edge updates land
    always @(posedge clk) begin
        if (irq0 === 1'b1) n_irq0++;
        if (irq1 === 1'b1) n_irq1++;
        if (wake === 1'b1) n_wake++;
        if (pa3_out !== pa3_q) n_tog++;
        pa3_q = pa3_out;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %h wanted %h", $time, msg,
                     seen, exp);
        end
    endtask

    // Range compare; an unknown value fails too
    task automatic in_rng(input logic [15:0] x, input int lo, input int hi,
                          input string msg);
        check({15'h0, x >= lo && x <= hi}, 16'h1, msg);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe; taken at the
    // edge that closes that cycle, so later stimulus stays on the edge
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] q,
                        input string msg);
        logic [7:0] d;
        bus_rd(a, d);
        check({8'h0, d}, {8'h0, q}, msg);
    endtask

    // One single-shot pulse measurement of the given polarity and width
    task automatic pw(input logic e, input int w);
        logic [7:0] d;
        i_tec_pin_src.level(~e, 8);
        bus_wr(`TEC_OFF_CNT0, 8'h00);
        bus_wr(`TEC_OFF_CTRL0, {4'hD, e, 3'h0});
        wait_clk(20);
        rchk(`TEC_OFF_CNT0, 8'h00, "armed only");
        i_tec_pin_src.level(e, w);
        i_tec_pin_src.level(~e, 10);
        rchk(`TEC_OFF_CTRL0, {4'hC, e, 3'h0}, "run clear");
        bus_rd(`TEC_OFF_CNT0, d);
        in_rng(d, w - 2, w + 2, "pulse width");
        i_tec_pin_src.pulses(1, 10);
        rchk(`TEC_OFF_CNT0, d, "later edges ignored");
        $display("Test done: pulse width");
    endtask

    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog: the tests need under 6000 clocks
    initial begin
        #1000000;
        err_total++;
        print_verdict();
    end

    initial begin
        wait_clk(16);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rchk(4'(i), rst_q[i], "reset value");
        check({15'h0, pa3_oe_n}, 16'h1, "pin is input");
        $display("Test done: reset");
        foreach (rows[i]) begin
            bus_wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].q, "register row");
        end
        $display("Test done: register rows");
        // Event counting on both edges, overflow, wake in power-down
        bus_wr(`TEC_OFF_INTEN, 8'h03);
        bus_wr(`TEC_OFF_CNT0, 8'hFD);
        bus_wr(`TEC_OFF_CTRL0, 8'h57);
        i_tec_pin_src.pulses(4, 4);
        rchk(`TEC_OFF_CNT0, 8'hFE, "rising events");
        check(16'(n_irq0), 16'h1, "one overflow");
        bus_wr(`TEC_OFF_CTRL0, 8'h5F);
        i_tec_pin_src.pulses(2, 4);
        rchk(`TEC_OFF_CNT0, 8'hFD, "falling events");
        rchk(`TEC_OFF_CTRL0, 8'h5F, "run kept");
        pwr_down <= 1'b1;
        bus_wr(`TEC_OFF_INTEN, 8'h00);
        bus_wr(`TEC_OFF_CNT0, 8'hFF);
        i_tec_pin_src.pulses(3, 4);
        rchk(`TEC_OFF_CNT0, 8'hFF, "preload on overflow");
        check(16'(n_wake), 16'h1, "wake");
        check(16'(n_irq0), 16'h2, "masked request");
        pwr_down <= 1'b0;
        $display("Test done: event counter");
        // Interval timer at three rates, about 16 ticks each time
        foreach (rates[i]) begin
            bus_wr(`TEC_OFF_CNT0, 8'h00);
            bus_wr(`TEC_OFF_CTRL0, {5'h12, rates[i]});
            wait_clk(16 << rates[i]);
            bus_wr(`TEC_OFF_CTRL0, {5'h10, rates[i]});
            bus_rd(`TEC_OFF_CNT0, v);
            in_rng(v, 15, 18, "timer ticks");
        end
        wait_clk(20);
        rchk(`TEC_OFF_CNT0, v, "stopped holds");
        $display("Test done: timer");
        // Wide counter: byte pairing, fsys/4 overflow, sub clock
        bus_wr(`TEC_OFF_CNT1L, 8'hF0);
        bus_wr(`TEC_OFF_CNT1H, 8'hFF);
        rchk(`TEC_OFF_CNT1H, 8'hFF, "wide high");
        rchk(`TEC_OFF_CNT1L, 8'hF0, "wide low");
        bus_wr(`TEC_OFF_INTEN, 8'h02);
        bus_wr(`TEC_OFF_CTRL1, 8'h90);
        wait_clk(80);
        bus_wr(`TEC_OFF_CTRL1, 8'h80);
        check(16'(n_irq1), 16'h1, "wide overflow");
        rchk(`TEC_OFF_CNT1H, 8'hFF, "wide reload");
        bus_rd(`TEC_OFF_CNT1L, v);
        in_rng(v, 8'hF3, 8'hF6, "fsys/4 ticks");
        bus_wr(`TEC_OFF_CNT1L, 8'h00);
        bus_wr(`TEC_OFF_CNT1H, 8'h00);
        bus_wr(`TEC_OFF_CTRL1, 8'hB0);
        repeat (10) begin
            sub_clk <= 1'b1;
            wait_clk(4);
            sub_clk <= 1'b0;
            wait_clk(4);
        end
        wait_clk(8);
        bus_wr(`TEC_OFF_CTRL1, 8'hA0);
        rchk(`TEC_OFF_CNT1H, 8'h00, "sub high");
        rchk(`TEC_OFF_CNT1L, 8'h0A, "sub ticks");
        // Event counting on the wide counter's own pin
        bus_wr(`TEC_OFF_CNT1L, 8'hFE);
        bus_wr(`TEC_OFF_CNT1H, 8'hFF);
        bus_wr(`TEC_OFF_CTRL1, 8'h50);
        repeat (3) begin
            i_tec_pin_src.level1(1'b1, 4);
            i_tec_pin_src.level1(1'b0, 4);
        end
        rchk(`TEC_OFF_CNT1H, 8'hFF, "wide events high");
        rchk(`TEC_OFF_CNT1L, 8'hFF, "wide events low");
        check(16'(n_irq1), 16'h2, "wide event overflow");
        $display("Test done: wide counter");
        // Divider on the shared pin, gated by direction and data
        bus_wr(`TEC_OFF_CFG, 8'h01);
        bus_wr(`TEC_OFF_PORT, 8'h02);
        bus_wr(`TEC_OFF_CNT0, 8'hF0);
        bus_wr(`TEC_OFF_CTRL0, 8'h90);
        check({15'h0, pa3_oe_n}, 16'h0, "pin drives");
        n_tog = 0;
        wait_clk(160);
        in_rng(16'(n_tog), 9, 11, "divider toggles");
        bus_wr(`TEC_OFF_PORT, 8'h00);
        wait_clk(4);
        n_tog = 0;
        wait_clk(64);
        check(16'(n_tog), 16'h0, "data low quiet");
        check({15'h0, pa3_out}, 16'h0, "data low");
        bus_wr(`TEC_OFF_CFG, 8'h00);
        bus_wr(`TEC_OFF_PORT, 8'h02);
        pa3_in <= 1'b1;
        wait_clk(4);
        check({15'h0, pa3_out}, 16'h1, "plain output");
        rchk(`TEC_OFF_PORT, 8'h06, "pin level");
        bus_wr(`TEC_OFF_CTRL0, 8'h00);
        $display("Test done: divider");
        pw(1'b0, 40);
        pw(1'b1, 20);
        print_verdict();
    end
endmodule
